// ===== tps_map.svh
/*
  Register map, field positions, reset values and timing counts for the
  timer prescaler block.
  Assumes a 10 MHz clock; one clock equals one instruction cycle.
*/
// Functional notes
// - An 8-bit counter divides the selected clock before it reaches the timer.
// - Every write to the timer low byte clears the prescaler while it is in use.
// - The prescaler count can be neither read nor written by software.
// - In 16-bit mode a write to the high-byte buffer leaves the prescaler alone.
// - A write to the high-byte buffer changes only the latch, not the timer.
// - A control bit enables the prescaler and three select bits read back as written.
// - With the prescaler in use the ratios run over powers of two from 1:2 to 1:256.
// - After a timer write incrementing is held off for two instruction cycles.
// - With the prescaler in use a write loads the timer at once and holds both counts.
// - At ratio 1:2 the timer holds for four input clocks after a write.
// - After the hold-off the timer advances once per ratio input clocks.
// - On a non-power-on reset the control register reads all ones.
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH
`define TPS_ADDR_W 2
`define TPS_OFF_LOW 2'h0
`define TPS_OFF_HIGH 2'h1
`define TPS_OFF_CTRL 2'h2
`define TPS_OFF_FLAGS 2'h3
`define TPS_CTRL_RST 8'hff
`define TPS_HIGH_RST 8'h00
`define TPS_FLAGS_RST 8'h00
`define TPS_BIT_RUN 7
`define TPS_BIT_W8 6
`define TPS_BIT_SRC 5
`define TPS_BIT_EDGE 4
`define TPS_BIT_PSA 3
`define TPS_PS_HI 2
`define TPS_PS_LO 0
`define TPS_BIT_OVF 2
`define TPS_BIT_OVIE 5
`define TPS_INHIBIT_CYC 2'h2
`endif

// ===== tps_pkg.sv
/*
  Types shared by the timer prescaler block.
  Assumes the map header supplies all numeric constants.
*/
package tps_pkg;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tps_bus_req_t;
endpackage

// ===== tps_timer.sv
/*
  Timer with 8-bit prescaler, post-write increment inhibit and a small
  register port.
  Assumes one clock per instruction cycle and an external count pin
  that is asynchronous to clk_i.
*/
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "tps_map.svh"
module tps_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic por_i,
  input wire tps_pkg::tps_bus_req_t bus_i,
  input wire logic ext_count_pin_i,
  output logic [7:0] rdata_o,
  output logic overflow_o
);
  import tps_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  logic rst_n;
  assign rst_n = rst_s2_reg;

  // Pin sync; the second stage and its delayed copy feed the edge detect
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_prev_reg;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= ext_count_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  logic [7:0] timer_control_reg;
  logic [7:0] timer_high_byte_buffer_reg;
  logic [15:0] timer_count_reg;
  logic [7:0] prescaler_reg;
  logic [1:0] inhibit_reg;
  logic overflow_flag_reg;
  logic overflow_irq_enable_reg;
  logic por_seen_reg;

  logic wr_low;
  logic wr_high;
  logic wr_ctrl;
  logic wr_flags;
  always_comb
  begin
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_ctrl = 1'b0;
    wr_flags = 1'b0;
    if (bus_i.wr && bus_i.addr == `TPS_OFF_LOW)
      wr_low = 1'b1;
    else if (bus_i.wr && bus_i.addr == `TPS_OFF_HIGH)
      wr_high = 1'b1;
    else if (bus_i.wr && bus_i.addr == `TPS_OFF_CTRL)
      wr_ctrl = 1'b1;
    else if (bus_i.wr && bus_i.addr == `TPS_OFF_FLAGS)
      wr_flags = 1'b1;
  end

  logic run_en;
  logic width8;
  logic prescaler_assign_bit;
  logic [2:0] prescale_select_field;
  assign run_en = timer_control_reg[`TPS_BIT_RUN];
  assign width8 = timer_control_reg[`TPS_BIT_W8];
  assign prescaler_assign_bit = timer_control_reg[`TPS_BIT_PSA];
  assign prescale_select_field = timer_control_reg[`TPS_PS_HI:`TPS_PS_LO];

  // Selected input tick: instruction clock or chosen pin edge
  logic src_tick;
  always_comb
  begin
    if (!timer_control_reg[`TPS_BIT_SRC])
      src_tick = 1'b1;
    else if (timer_control_reg[`TPS_BIT_EDGE])
      src_tick = pin_prev_reg && !pin_s2_reg;
    else
      src_tick = !pin_prev_reg && pin_s2_reg;
  end

  logic hold;
  assign hold = (inhibit_reg != 2'h0);
  logic in_tick;
  assign in_tick = run_en && src_tick && !hold;

  // Terminal count: all low bits up to the select position set
  logic [7:0] ps_mask;
  assign ps_mask = 8'hff >> (3'h7 - prescale_select_field);
  logic ps_done;
  assign ps_done = ((prescaler_reg & ps_mask) == ps_mask);
  logic timer_tick;
  assign timer_tick = prescaler_assign_bit ? (in_tick && ps_done) : in_tick;

  ////////////////////////////////////////////////////////////////
  // Count is internal only; no decode reaches it
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      prescaler_reg <= 8'h00;
    else if (wr_low && prescaler_assign_bit)
      prescaler_reg <= 8'h00;
    else if (prescaler_assign_bit && in_tick)
      prescaler_reg <= ps_done ? 8'h00 : prescaler_reg + 8'h01;
  end

  // Two-cycle hold; at 1:2 this costs four input clocks total
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      inhibit_reg <= 2'h0;
    else if (wr_low)
      inhibit_reg <= `TPS_INHIBIT_CYC;
    else if (hold)
      inhibit_reg <= inhibit_reg - 2'h1;
  end

  logic [15:0] count_inc;
  assign count_inc = timer_count_reg + 16'h0001;
  logic wrap;
  assign wrap = timer_tick && (width8 ? (timer_count_reg[7:0] == 8'hff)
                                      : (timer_count_reg == 16'hffff));

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      timer_count_reg <= 16'h0000;
    else if (wr_low)
      timer_count_reg <= width8 ? {8'h00, bus_i.wdata}
                                : {timer_high_byte_buffer_reg, bus_i.wdata};
    else if (timer_tick)
      timer_count_reg <= width8 ? {8'h00, count_inc[7:0]} : count_inc;
  end

  // High buffer: latch only, timer unaffected
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      timer_high_byte_buffer_reg <= `TPS_HIGH_RST;
    else if (wr_high)
      timer_high_byte_buffer_reg <= bus_i.wdata;
    else if (bus_i.rd && bus_i.addr == `TPS_OFF_LOW && !width8)
      timer_high_byte_buffer_reg <= timer_count_reg[15:8];
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      timer_control_reg <= `TPS_CTRL_RST;
    else if (wr_ctrl)
      timer_control_reg <= bus_i.wdata;
  end

  // Power-on caught after release; kept but never read out
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      por_seen_reg <= 1'b0;
    else if (por_i)
      por_seen_reg <= 1'b1;
  end

  // Set beats clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overflow_flag_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
    end
    else
    begin
      if (wrap)
        overflow_flag_reg <= 1'b1;
      else if (wr_flags)
        overflow_flag_reg <= bus_i.wdata[`TPS_BIT_OVF];
      if (wr_flags)
        overflow_irq_enable_reg <= bus_i.wdata[`TPS_BIT_OVIE];
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= 8'h00;
    else if (!bus_i.rd)
      rdata_o <= 8'h00;
    else if (bus_i.addr == `TPS_OFF_LOW)
      rdata_o <= timer_count_reg[7:0];
    else if (bus_i.addr == `TPS_OFF_HIGH)
      rdata_o <= width8 ? 8'h00 : timer_high_byte_buffer_reg;
    else if (bus_i.addr == `TPS_OFF_CTRL)
      rdata_o <= timer_control_reg;
    else
    begin
      rdata_o <= `TPS_FLAGS_RST;
      rdata_o[`TPS_BIT_OVF] <= overflow_flag_reg;
      rdata_o[`TPS_BIT_OVIE] <= overflow_irq_enable_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      overflow_o <= 1'b0;
    else
      overflow_o <= overflow_flag_reg && overflow_irq_enable_reg;
  end
endmodule

// ===== tps_timer_assertions.sv
/* Port checker for the timer block.
   Assumes it is bound to tps_timer and sees its ports only. */
`timescale 1ns/1ns
module tps_timer_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire tps_pkg::tps_bus_req_t bus_i,
  input wire logic [7:0] rdata_o
);
  import tps_pkg::*;
  logic [7:0] ctl_reg;
  logic cw_reg;
  logic byp;
  logic pre2;
  // Control shadow, all ones from any reset
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      ctl_reg <= 8'hff;
      cw_reg <= 1'b0;
    end
    else if (bus_i.wr && bus_i.addr == 2'h2)
    begin
      ctl_reg <= bus_i.wdata;
      cw_reg <= 1'b1;
    end
  assign byp = {ctl_reg[7], ctl_reg[5], ctl_reg[3]} == 3'b100;
  assign pre2 = {ctl_reg[7], ctl_reg[5], ctl_reg[3:0]} == 6'b101000;
  //////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rl; bus_i.rd && bus_i.addr == 2'h0; endsequence
  sequence s_wl; bus_i.wr && bus_i.addr == 2'h0; endsequence
  property p_rd_idle; !bus_i.rd |=> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rd idle");
  property p_ctl_rst; bus_i.rd && bus_i.addr == 2'h2 && !cw_reg |=> rdata_o == 8'hff; endproperty
  a_ctl_rst: assert property (p_ctl_rst) else $error("ctl rst");
  property p_ctl_rb;
    bus_i.wr && bus_i.addr == 2'h2 ##1 bus_i.rd && bus_i.addr == 2'h2
      |=> rdata_o == $past(bus_i.wdata, 2);
  endproperty
  a_ctl_rb: assert property (p_ctl_rb) else $error("ctl rb");
  property p_inh1; s_wl ##1 s_rl |=> rdata_o == $past(bus_i.wdata, 2); endproperty
  a_inh1: assert property (p_inh1) else $error("inh1");
  property p_inh2; s_wl ##1 s_rl[*2] |=> rdata_o == $past(bus_i.wdata, 3); endproperty
  a_inh2: assert property (p_inh2) else $error("inh2");
  property p_pre2; pre2 ##0 s_wl ##1 s_rl[*3] |=> rdata_o == $past(bus_i.wdata, 4); endproperty
  a_pre2: assert property (p_pre2) else $error("pre2");
  property p_byp;
    (byp && !$past(bus_i.wr) && !$past(bus_i.wr, 2)) ##0 s_rl ##1 s_rl
      |=> rdata_o == $past(rdata_o) + 8'h01;
  endproperty
  a_byp: assert property (p_byp) else $error("byp");
  property p_hbuf;
    !ctl_reg[6] && bus_i.wr && bus_i.addr == 2'h1 ##1 bus_i.rd && bus_i.addr == 2'h1
      |=> rdata_o == $past(bus_i.wdata, 2);
  endproperty
  a_hbuf: assert property (p_hbuf) else $error("hbuf");
endmodule

// ===== tb_top.sv
/* Self-checking bench for the timer block.
   Assumes package, design and checker are compiled first. */
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import tps_pkg::*;
  logic clk_i = 0;
  logic rst_n_i = 0;
  logic pin = 0;
  tps_bus_req_t bus_i = '0;
  logic [7:0] rdata_o;
  logic ovf;
  logic [7:0] rq[$];
  logic [7:0] d;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  tps_timer u_tps_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .por_i(1'b0), .bus_i(bus_i),
    .ext_count_pin_i(pin), .rdata_o(rdata_o), .overflow_o(ovf));
  //////////////////////////////////////////
  // Each edge logs the result of the previous request
  task op(input logic [1:0] a, input logic [7:0] v, input logic w);
    bus_i <= '{a, v, w, !w};
    @(posedge clk_i);
    rq.push_back(rdata_o);
  endtask
  task idle();
    bus_i <= '0;
    @(posedge clk_i);
    rq.push_back(rdata_o);
  endtask
  task rst_chk();
    rst_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    op(2'h2, 8'h00, 1'b0);
    op(2'h1, 8'h00, 1'b0);
    idle();
    `CHK(rq[$ - 1], 8'hff)
    `CHK(rq[$], 8'h00)
    $display("reset test done");
  endtask
  // Model: j-th read after a low write sees v + max(0, j-3) / ratio
  task run(input logic [7:0] c, input int rt);
    int k;
    logic [7:0] v;
    v = 8'($urandom);
    k = 2 * rt + 4;
    op(2'h2, c, 1'b1);
    repeat ($urandom_range(rt)) idle();
    rq.delete();
    op(2'h0, v, 1'b1);
    repeat (k) op(2'h0, 8'h00, 1'b0);
    idle();
    for (int j = 1; j <= k; j++)
      `CHK(rq[j + 1], v + 8'((j > 3 ? j - 3 : 0) / rt))
    $display("mode %h done", c);
  endtask
  task test_done();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, far above the under two thousand cycles needed
  always @(posedge clk_i)
  begin
    pin <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    void'($urandom(33720));
    rst_chk();
    repeat (4)
    begin
      d = 8'($urandom);
      op(2'h2, d, 1'b1);
      op(2'h2, 8'h00, 1'b0);
      idle();
      `CHK(rq[$], d)
    end
    d = 8'($urandom);
    op(2'h2, 8'h80, 1'b1);
    op(2'h1, d, 1'b1);
    op(2'h0, 8'h00, 1'b1);
    op(2'h1, ~d, 1'b1);
    op(2'h1, 8'h00, 1'b0);
    op(2'h0, 8'h00, 1'b0);
    op(2'h1, 8'h00, 1'b0);
    idle();
    `CHK(rq[$ - 2], ~d)
    `CHK(rq[$], d)
    $display("high buffer test done");
    run(8'hc0 | 8'($urandom_range(7)), 1);
    for (int n = 0; n < 8; n++)
      run(8'hc8 | 8'(n), 2 << n);
    // Preload three below wrap; two counts go to the hold-off
    op(2'h2, 8'hc0, 1'b1);
    op(2'h3, 8'h20, 1'b1);
    op(2'h0, 8'hfd, 1'b1);
    repeat (8) idle();
    op(2'h3, 8'h00, 1'b0);
    idle();
    `CHK(rq[$], 8'h24)
    `CHK(ovf, 1'b1)
    op(2'h3, 8'h00, 1'b1);
    idle();
    idle();
    `CHK(ovf, 1'b0)
    $display("overflow test done");
    rst_chk();
    test_done();
  end
endmodule
bind tps_timer tps_timer_chk u_tps_timer_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .bus_i(bus_i), .rdata_o(rdata_o));
